/* logic/dfc_pkg.sv */
// constants and state types for the supervision and calibration block
package dfc_pkg;

    // ==========================================================
    // frame command bytes and register addresses
    localparam logic [7:0]  ADDR_CODE   = 8'h01;
    localparam logic [7:0]  ADDR_READ   = 8'h02;
    localparam logic [7:0]  ADDR_CFG    = 8'h57;
    localparam logic [7:0]  ADDR_GAIN   = 8'h58;
    localparam logic [7:0]  ADDR_ZERO   = 8'h59;
    localparam logic [7:0]  ADDR_STAT   = 8'h5a;
    localparam logic [7:0]  ADDR_WDOG   = 8'h95;
    localparam logic [7:0]  ADDR_SWRST  = 8'h96;

    // ==========================================================
    // configuration and status field positions
    localparam int          CFG_WATCHDOG_ENABLE_BIT    = 0;
    localparam int          CFG_WATCHDOG_PERIOD_FIELD    = 1;
    localparam int          CFG_FRAME_CHECK_ENABLE   = 3;
    localparam int          ST_OTEMP    = 0;
    localparam int          ST_WDFLT    = 1;
    localparam int          ST_CRCFLT   = 2;
    localparam int          ST_OPEN     = 3;
    localparam int          ST_HEAD     = 4;

    // ==========================================================
    // reset values and code limits
    localparam logic [15:0] GAIN_RST    = 16'h0000;
    localparam logic [15:0] ZERO_RST    = 16'h0000;
    localparam logic [15:0] CODE_LO     = 16'h0000;
    localparam logic [15:0] CODE_MID    = 16'h8000;
    localparam logic [15:0] CODE_MAX    = 16'hffff;
    localparam logic [32:0] GAIN_HALF   = 33'h0_0000_8000;

    // ==========================================================
    // frame check and timing
    localparam logic [7:0]  CRC_POLY    = 8'h07;
    localparam logic [5:0]  CRC_LEN32   = 6'h20;
    localparam logic [5:0]  CRC_LEN24   = 6'h18;
    localparam logic [4:0]  FRAME_LAST  = 5'h1f;
    localparam logic [7:0]  TEMP_SET_C  = 8'h8e;
    localparam logic [7:0]  TEMP_CLR_C  = 8'h7c;
    localparam int          CORE_MHZ    = 125;
    localparam int          OSC_MHZ     = 8;
    localparam int          OSC_KHZ     = OSC_MHZ * 1000;
    localparam int          WD_T0_MS    = 10;
    localparam int          WD_T1_MS    = 51;
    localparam int          WD_T2_MS    = 102;
    localparam int          WD_T3_MS    = 204;
    localparam logic [8:0]  PH_STEP     = 9'(OSC_MHZ);
    localparam logic [8:0]  PH_WRAP     = 9'(CORE_MHZ);

    typedef enum logic [1:0] {
        ST_SYNC0 = 2'b00,
        ST_SYNC1 = 2'b01,
        ST_LOAD  = 2'b10,
        ST_RUN   = 2'b11
    } dfc_state_e;

    typedef struct packed {
        dfc_state_e  st;
        logic        lat_s1, lat_s2, lat_s3;
        logic        tgl_s1, tgl_s2, tgl_s3;
        logic        clk_s1, clk_s2, clk_s3;
        logic        seen_clk;
        logic        sel_s1, sel_s2;
        logic        open_s1, open_s2;
        logic        head_s1, head_s2;
        logic [7:0]  temp_s1, temp_s2;
        logic        pend_ok;
        logic [31:0] pend;
        logic        wd_en;
        logic [1:0]  wd_pd;
        logic        crc_en;
        logic [15:0] gain, zero, code, out;
        logic        watchdog_fault_flag, frame_check_fault_flag, otemp, alarm;
        logic [7:0]  ph;
        logic [20:0] wd_cnt;
        logic [31:0] rd_word;
    } dfc_core_s;

    typedef struct packed {
        logic [31:0] shift;
        logic [31:0] word;
        logic        done_tgl;
        logic        edge_tgl;
        logic [31:0] tx;
        logic        sdo;
    } dfc_link_s;

endpackage

/* logic/dfc_top.sv */
// supervision, frame check, watchdog and calibration logic
//
// Behaviour
// - logic held in reset while either supply detector reports low
// - reset restores all defaults; data default chosen by clear select pin
// - fault pin low on open loop, headroom, overtemp, watchdog, check error
// - overtemp alarm set above 142 C, released only below 124 C
// - watchdog runs only when enabled; period field picks 10/51/102/204 ms
// - watchdog timed from an 8 MHz tick independent of serial clock
// - frame with address 0x95 restarts watchdog; expiry sets fault flag
// - watchdog fault clears only on software reset, disable or reset
// - frame check uses polynomial x^8+x^2+x+1 when enabled
// - checked frames are 32 bits: 24 command bits then 8 check bits
// - readback in checked mode appends device check byte to output
// - checked mode evaluates remainder every 32 serial clocks
// - nonzero remainder sets check fault flag and fault pin
// - a frame failing the check changes nothing
// - check fault clears on 0x96 software reset, disable or reset
// - latch pulse without clocks is a no-op realigning the bit count
// - a data write sets output to code*(gain+2^15)/2^16 plus signed zero trim; reset loads the default code untrimmed
// - gain trim resets to 0x0000, a gain of one half
// - calibrated code saturates within 0x0000..0xffff
// - trim changes apply only at the next data register write
`timescale 1ns/1ps

module dfc_top
    import dfc_pkg::*;
#(
    parameter int unsigned WD_TICKS0 = WD_T0_MS * OSC_KHZ,
    parameter int unsigned WD_TICKS1 = WD_T1_MS * OSC_KHZ,
    parameter int unsigned WD_TICKS2 = WD_T2_MS * OSC_KHZ,
    parameter int unsigned WD_TICKS3 = WD_T3_MS * OSC_KHZ
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        digital_supply_good,
    input  wire logic        analog_supply_good,
    input  wire logic        clear_level_select,
    input  wire logic        open_loop_det,
    input  wire logic        low_headroom_det,
    input  wire logic [7:0]  die_temp_c,
    input  wire logic        serial_clk,
    input  wire logic        serial_in,
    input  wire logic        latch_strobe,
    output logic             serial_out,
    input  wire logic        fault_n_in,
    output logic             fault_n_out,
    output logic             fault_n_oe,
    output logic [15:0]      output_code_q
);

    // ==========================================================
    // helpers

    // msb-first division, zero start value, no inversion
    function automatic logic [7:0] crc_calc(input logic [31:0] d,
                                            input logic [5:0]  n);
        logic [7:0] r;
        logic       fb;
        r  = 8'h00;
        fb = 1'b0;
        for (int i = 0; i < 32; i++) begin
            if (6'(i) < n) begin
                fb = r[7] ^ d[31-i];
                r  = {r[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
            end
        end
        return r;
    endfunction

    // gain and zero correction with clamping
    function automatic logic [15:0] cal_code(input logic [15:0] c,
                                             input logic [15:0] g,
                                             input logic [15:0] z);
        logic [32:0]        p;
        logic signed [18:0] s;
        p = {17'h0_0000, c} * ({17'h0_0000, g} + GAIN_HALF);
        s = $signed({2'b00, p[32:16]}) + $signed({{3{z[15]}}, z});
        if (s < 0)
            return CODE_LO;
        else if (s > $signed({3'b000, CODE_MAX}))
            return CODE_MAX;
        else
            return s[15:0];
    endfunction

    // ==========================================================
    // reset generation

    logic       por_b;
    logic [1:0] rst_sync_r;
    logic       sys_rst_b;
    logic       link_clr_b;

    // both supply detectors must be good; release is synchronised
    assign por_b = rst_b & digital_supply_good & analog_supply_good;

    always_ff @(posedge core_clk or negedge por_b) begin
        if (!por_b)
            rst_sync_r <= 2'b00;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end

    assign sys_rst_b  = rst_sync_r[1];
    // latch high clears alignment; serial clock is idle then
    assign link_clr_b = sys_rst_b & ~latch_strobe;

    // ==========================================================
    // link side, clocked by the serial clock

    dfc_link_s  link_r;
    dfc_link_s  link_nxt;
    dfc_core_s  core_r;
    dfc_core_s  core_nxt;
    logic [4:0] bit_cnt_r;

    always_ff @(posedge serial_clk or negedge link_clr_b) begin
        if (!link_clr_b)
            bit_cnt_r <= 5'h00;
        else
            bit_cnt_r <= bit_cnt_r + 5'h01; // wraps every 32 bits
    end

    // shift in; every 32nd clock hand a whole frame over
    always_comb begin
        link_nxt          = link_r;
        link_nxt.shift    = {link_r.shift[30:0], serial_in};
        link_nxt.edge_tgl = ~link_r.edge_tgl;
        if (bit_cnt_r == FRAME_LAST) begin
            link_nxt.word     = {link_r.shift[30:0], serial_in};
            link_nxt.done_tgl = ~link_r.done_tgl;
        end
        // rd_word was settled at the previous commit, long before
        if (bit_cnt_r == 5'h00) begin
            link_nxt.sdo = core_r.rd_word[31];
            link_nxt.tx  = {core_r.rd_word[30:0], 1'b0};
        end else begin
            link_nxt.sdo = link_r.tx[31];
            link_nxt.tx  = {link_r.tx[30:0], 1'b0};
        end
    end

    always_ff @(posedge serial_clk or negedge sys_rst_b) begin
        if (!sys_rst_b)
            link_r <= '0;
        else
            link_r <= link_nxt;
    end

    // ==========================================================
    // core side

    logic [20:0] wd_limit;

    // period field selects the tick count
    always_comb begin
        unique case (core_r.wd_pd)
            2'b00: wd_limit = 21'(WD_TICKS0 - 1);
            2'b01: wd_limit = 21'(WD_TICKS1 - 1);
            2'b10: wd_limit = 21'(WD_TICKS2 - 1);
            2'b11: wd_limit = 21'(WD_TICKS3 - 1);
        endcase
    end

    always_comb begin
        logic [23:0] frame;
        logic        commit;
        logic        crc_err;
        logic        wd_exp;
        logic        tick;
        logic        swrst;
        logic [8:0]  phs;
        logic [15:0] rdv;
        logic [23:0] resp;
        frame    = 24'h00_0000;
        commit   = 1'b0;
        crc_err  = 1'b0;
        wd_exp   = 1'b0;
        swrst    = 1'b0;
        rdv      = 16'h0000;
        resp     = 24'h00_0000;
        phs      = {1'b0, core_r.ph} + PH_STEP;
        tick     = (phs >= PH_WRAP);
        core_nxt = core_r;

        // pin and cross-domain synchronisers, first stage read only here
        core_nxt.lat_s1  = latch_strobe;
        core_nxt.lat_s2  = core_r.lat_s1;
        core_nxt.lat_s3  = core_r.lat_s2;
        core_nxt.tgl_s1  = link_r.done_tgl;
        core_nxt.tgl_s2  = core_r.tgl_s1;
        core_nxt.tgl_s3  = core_r.tgl_s2;
        core_nxt.clk_s1  = link_r.edge_tgl;
        core_nxt.clk_s2  = core_r.clk_s1;
        core_nxt.clk_s3  = core_r.clk_s2;
        core_nxt.sel_s1  = clear_level_select;
        core_nxt.sel_s2  = core_r.sel_s1;
        core_nxt.open_s1 = open_loop_det;
        core_nxt.open_s2 = core_r.open_s1;
        core_nxt.head_s1 = low_headroom_det;
        core_nxt.head_s2 = core_r.head_s1;
        // slow sensor code; a torn sample only lasts one cycle
        core_nxt.temp_s1 = die_temp_c;
        core_nxt.temp_s2 = core_r.temp_s1;

        // any serial edge since the last latch marks a real frame
        if (core_r.clk_s2 != core_r.clk_s3)
            core_nxt.seen_clk = 1'b1;

        // power-up sequence: wait for the strap to settle, then load
        unique case (core_r.st)
            ST_SYNC0: core_nxt.st = ST_SYNC1;
            ST_SYNC1: core_nxt.st = ST_LOAD;
            ST_LOAD: begin
                core_nxt.code = core_r.sel_s2 ? CODE_MID : CODE_LO;
                core_nxt.out  = core_nxt.code;
                core_nxt.st   = ST_RUN;
            end
            ST_RUN:   core_nxt.st = ST_RUN;
        endcase

        // 32-bit frame arrived: check it, keep it only if clean
        if (core_r.tgl_s2 != core_r.tgl_s3 && core_r.crc_en) begin
            if (crc_calc(link_r.word, CRC_LEN32) == 8'h00) begin
                core_nxt.pend    = link_r.word;
                core_nxt.pend_ok = 1'b1;
            end else begin
                core_nxt.pend_ok = 1'b0;
                crc_err          = 1'b1;
            end
        end

        // latch rising edge commits; shift is quiet once latch is high
        if (core_r.lat_s2 && !core_r.lat_s3 && core_r.st == ST_RUN) begin
            if (core_r.crc_en) begin
                commit = core_nxt.pend_ok;
                frame  = core_nxt.pend[31:8];
            end else begin
                commit = core_r.seen_clk;
                frame  = link_r.shift[23:0];
            end
            core_nxt.pend_ok  = 1'b0;
            core_nxt.seen_clk = 1'b0;
        end

        // command decode
        if (commit) begin
            case (frame[23:16])
                ADDR_CODE: begin
                    core_nxt.code = frame[15:0];
                    core_nxt.out  = cal_code(frame[15:0], core_r.gain,
                                             core_r.zero);
                end
                ADDR_CFG: begin
                    core_nxt.wd_en  = frame[CFG_WATCHDOG_ENABLE_BIT];
                    core_nxt.wd_pd  = frame[CFG_WATCHDOG_PERIOD_FIELD +: 2];
                    core_nxt.crc_en = frame[CFG_FRAME_CHECK_ENABLE];
                end
                ADDR_GAIN: core_nxt.gain = frame[15:0];
                ADDR_ZERO: core_nxt.zero = frame[15:0];
                ADDR_READ: begin
                    case (frame[7:0])
                        ADDR_CODE: rdv = core_r.code;
                        ADDR_CFG:  rdv = {12'h000, core_r.crc_en,
                                          core_r.wd_pd, core_r.wd_en};
                        ADDR_GAIN: rdv = core_r.gain;
                        ADDR_ZERO: rdv = core_r.zero;
                        ADDR_STAT: begin
                            rdv[ST_OTEMP]  = core_r.otemp;
                            rdv[ST_WDFLT]  = core_r.watchdog_fault_flag;
                            rdv[ST_CRCFLT] = core_r.frame_check_fault_flag;
                            rdv[ST_OPEN]   = core_r.open_s2;
                            rdv[ST_HEAD]   = core_r.head_s2;
                        end
                        default:   rdv = 16'h0000;
                    endcase
                    resp = {frame[7:0], rdv};
                    if (core_r.crc_en)
                        core_nxt.rd_word = {resp,
                            crc_calc({resp, 8'h00}, CRC_LEN24)};
                    else
                        core_nxt.rd_word = {resp, 8'h00};
                end
                ADDR_SWRST: swrst = 1'b1;
                default: ;
            endcase
        end

        // software reset: back to defaults, data reloaded from strap
        if (swrst) begin
            core_nxt.gain    = GAIN_RST;
            core_nxt.zero    = ZERO_RST;
            core_nxt.wd_en   = 1'b0;
            core_nxt.wd_pd   = 2'b00;
            core_nxt.crc_en  = 1'b0;
            core_nxt.rd_word = 32'h0000_0000;
            core_nxt.st      = ST_LOAD;
        end

        // 8 MHz tick by fractional accumulation of the core clock
        core_nxt.ph = tick ? 8'(phs - PH_WRAP) : phs[7:0];

        // watchdog count, restarted by the service frame
        if (!core_nxt.wd_en ||
            (commit && frame[23:16] == ADDR_WDOG)) begin
            core_nxt.wd_cnt = 21'h00_0000;
        end else if (tick && core_r.wd_en) begin
            if (core_r.wd_cnt >= wd_limit) begin
                core_nxt.wd_cnt = 21'h00_0000;
                wd_exp          = 1'b1;
            end else begin
                core_nxt.wd_cnt = core_r.wd_cnt + 21'h00_0001;
            end
        end

        // sticky faults: clear first, so a same-cycle event still sets
        if (swrst || !core_nxt.wd_en)
            core_nxt.watchdog_fault_flag = 1'b0;
        if (wd_exp)
            core_nxt.watchdog_fault_flag = 1'b1;
        if (swrst || !core_nxt.crc_en)
            core_nxt.frame_check_fault_flag = 1'b0;
        if (crc_err)
            core_nxt.frame_check_fault_flag = 1'b1;

        // thermal alarm with hysteresis
        if (core_r.temp_s2 > TEMP_SET_C)
            core_nxt.otemp = 1'b1;
        else if (core_r.temp_s2 < TEMP_CLR_C)
            core_nxt.otemp = 1'b0;

        // fault pin pulls low while any enabled source is active
        core_nxt.alarm = core_r.open_s2 | core_r.head_s2 | core_r.otemp
                       | (core_r.watchdog_fault_flag & core_r.wd_en)
                       | (core_r.frame_check_fault_flag & core_r.crc_en);
    end

    // power-on clears every register; gain named for its half default
    always_ff @(posedge core_clk or negedge sys_rst_b) begin
        if (!sys_rst_b) begin
            core_r      <= '0;
            core_r.gain <= GAIN_RST;
        end else begin
            core_r      <= core_nxt;
        end
    end

    // ==========================================================
    // outputs; the fault pin is open drain and only ever pulls low

    assign fault_n_out   = 1'b0;
    assign fault_n_oe    = core_r.alarm;
    assign serial_out    = link_r.sdo;
    assign output_code_q = core_r.out;

endmodule // dfc_top

/* test/dfc_host_model.sv */
// host controller model that clocks frames into the serial port
`timescale 1ns/1ps
module dfc_host_model
    import dfc_pkg::*;
(
    output logic      serial_clk,
    output logic      serial_in,
    output logic      latch_strobe,
    input  wire logic serial_out
);
    // ==========================================================
    // link state
    logic [31:0] rx_word;
    // link clock rests low between frames; it only runs inside one
    initial begin
        serial_clk = 1'b0;
        serial_in = 1'b1;
        latch_strobe = 1'b1;
        rx_word = '0;
    end
    // check byte: msb first, zero start, no final inversion
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 23; i >= 0; i--) begin
            r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? CRC_POLY : 8'h00);
        end
        return r;
    endfunction
    // one frame of n bits, msb first; readback captured on falling edges
    task automatic send(input logic [31:0] w, input int n);
        #37;
        latch_strobe = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_in = w[i];
            #62.5 serial_clk = 1'b1;
            #62.5 serial_clk = 1'b0;
            rx_word = {rx_word[30:0], serial_out};
        end
        serial_in = ~serial_in; // released line must not look held
        #62.5 latch_strobe = 1'b1;
        #125;
    endtask
    // latch pulse with no clocks realigns the bit count
    task automatic nop();
        #37 latch_strobe = 1'b0;
        #250 latch_strobe = 1'b1;
        #250;
    endtask
endmodule // dfc_host_model

/* test/dfc_properties.sv */
// port-level assertion checker for the supervision block
`timescale 1ns/1ps
module dfc_properties
    import dfc_pkg::*;
(
    input wire logic        core_clk,
    input wire logic        rst_b,
    input wire logic        digital_supply_good,
    input wire logic        analog_supply_good,
    input wire logic        open_loop_det,
    input wire logic        low_headroom_det,
    input wire logic [7:0]  die_temp_c,
    input wire logic        latch_strobe,
    input wire logic        fault_n_out,
    input wire logic        fault_n_oe,
    input wire logic [15:0] output_code_q
);
    // ==========================================================
    // helper logic
    logic [3:0] since_r;
    logic       lat_r;
    logic       evt;
    // a commit or a reset restarts the count; it saturates, never wraps
    assign evt = !(rst_b && digital_supply_good && analog_supply_good)
                 || (latch_strobe && !lat_r);
    always_ff @(posedge core_clk) begin
        lat_r <= latch_strobe;
        if (evt) begin
            since_r <= 4'h0;
        end else if (since_r != 4'hf) begin
            since_r <= since_r + 4'h1;
        end
    end

    // ==========================================================
    // properties
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    sequence hot_s;
        (die_temp_c > TEMP_SET_C) [*4];
    endsequence
    sequence warm_s;
        (die_temp_c >= TEMP_CLR_C && die_temp_c <= TEMP_SET_C) [*4];
    endsequence

    a_pin_low: assert property (fault_n_out == 1'b0)
        else $error("fault pin drives a high level");
    a_hot_alarm: assert property (hot_s |-> ##[0:3] fault_n_oe)
        else $error("overtemperature gave no alarm");
    a_temp_hyst: assert property (hot_s ##1 warm_s |-> fault_n_oe)
        else $error("alarm released above the lower threshold");
    a_open_alarm: assert property (open_loop_det [*4] |=> fault_n_oe)
        else $error("open loop gave no alarm");
    a_head_alarm: assert property ($rose(low_headroom_det)
        ##1 low_headroom_det [*3] |=> fault_n_oe)
        else $error("low headroom gave no alarm");
    a_dig_hold: assert property (!digital_supply_good |=>
        !fault_n_oe && output_code_q == CODE_LO)
        else $error("logic active while digital supply low");
    a_ana_hold: assert property ((!analog_supply_good) [*2] |->
        !fault_n_oe && output_code_q == CODE_LO)
        else $error("logic active while analog supply low");
    a_code_cause: assert property ($changed(output_code_q)
        && digital_supply_good && analog_supply_good
        |-> since_r <= 4'h6)
        else $error("output moved without a commit");
endmodule // dfc_properties

bind dfc_top dfc_properties u_dfc_properties (
    .core_clk(core_clk), .rst_b(rst_b),
    .digital_supply_good(digital_supply_good),
    .analog_supply_good(analog_supply_good),
    .open_loop_det(open_loop_det), .low_headroom_det(low_headroom_det),
    .die_temp_c(die_temp_c), .latch_strobe(latch_strobe),
    .fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe),
    .output_code_q(output_code_q));

/* test/dfc_top_tb_top.sv */
// self-checking bench for the supervision and calibration block
`timescale 1ns/1ps
module dfc_top_tb_top;
    import dfc_pkg::*;
    localparam int T0 = 120; // shortened watchdog count, 8 MHz ticks
    logic        core_clk, rst_b, digital_supply_good, analog_supply_good;
    logic        clear_level_select, open_loop_det, low_headroom_det;
    logic [7:0]  die_temp_c;
    wire         serial_clk, serial_in, latch_strobe, serial_out;
    wire         fault_n_out, fault_n_oe, fault_n_in;
    wire  [15:0] output_code_q;
    int          err_count, compares, seed, g, z, c, t;
    bit          crc_on;
    logic [15:0] exp_q;

    // ==========================================================
    // design, host and wire
    assign fault_n_in = fault_n_oe ? fault_n_out : 1'b1; // pull-up
    dfc_top #(.WD_TICKS0(T0), .WD_TICKS1(2 * T0), .WD_TICKS2(3 * T0),
        .WD_TICKS3(4 * T0)) u_dfc_top (
        .core_clk(core_clk), .rst_b(rst_b),
        .digital_supply_good(digital_supply_good),
        .analog_supply_good(analog_supply_good),
        .clear_level_select(clear_level_select),
        .open_loop_det(open_loop_det), .low_headroom_det(low_headroom_det),
        .die_temp_c(die_temp_c), .serial_clk(serial_clk),
        .serial_in(serial_in), .latch_strobe(latch_strobe),
        .serial_out(serial_out), .fault_n_in(fault_n_in),
        .fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe),
        .output_code_q(output_code_q));
    dfc_host_model u_dfc_host_model (.serial_clk(serial_clk),
        .serial_in(serial_in), .latch_strobe(latch_strobe),
        .serial_out(serial_out));

    // core clock, 8 ns
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // ==========================================================
    // tasks and reference model
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // 24-bit frame, or 32-bit with the host's check byte
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        if (crc_on) begin
            u_dfc_host_model.send({a, d, u_dfc_host_model.crc8({a, d})}, 32);
        end else begin
            u_dfc_host_model.send({8'h00, a, d}, 24);
        end
        cyc(4);
    endtask
    // integer model of the trim datapath, clamped to the code range
    function automatic logic [15:0] cal(int cd, int gn, int zr);
        longint v;
        v = (longint'(cd) * (gn + 32768)) / 65536 + zr;
        v = (v < 0) ? 0 : (v > 65535) ? 65535 : v;
        return 16'(v);
    endfunction
    task automatic finish_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (90000) @(posedge core_clk);
        err_count++;
        $display("MISMATCH at %0t: run timed out", $time);
        finish_test();
    end

    // ==========================================================
    // main sequence
    initial begin
        seed = 32'h2c09;
        err_count = 0;
        compares = 0;
        crc_on = 1'b0;
        rst_b = 1'b0;
        digital_supply_good = 1'b1;
        analog_supply_good = 1'b1;
        clear_level_select = 1'b1;
        open_loop_det = 1'b0;
        low_headroom_det = 1'b0;
        die_temp_c = 8'h19;
        cyc(20);
        rst_b = 1'b1;
        cyc(12);
        chk(output_code_q, CODE_MID);
        chk(16'(fault_n_oe), 16'h0000);
        // supply dip with the strap changed
        clear_level_select = 1'b0;
        analog_supply_good = 1'b0;
        cyc(3);
        chk(output_code_q, CODE_LO);
        {analog_supply_good, digital_supply_good} = 2'b10;
        cyc(3);
        digital_supply_good = 1'b1;
        cyc(12);
        chk(output_code_q, CODE_LO);
        // trims: boundaries first, then random values
        c = {$random(seed)} % 65536;
        wr(ADDR_CODE, 16'(c));
        chk(output_code_q, cal(c, 0, 0));
        for (int i = 0; i < 6; i++) begin
            exp_q = output_code_q;
            g = (i == 0) ? 65535 : {$random(seed)} % 65536;
            z = (i == 0) ? 32767 : (i == 1) ? -32768 : $random(seed) % 32768;
            c = (i == 0) ? 65535 : (i == 1) ? 100 : {$random(seed)} % 65536;
            wr(ADDR_GAIN, 16'(g));
            wr(ADDR_ZERO, 16'(z));
            chk(output_code_q, exp_q);
            wr(ADDR_CODE, 16'(c));
            chk(output_code_q, cal(c, g, z));
        end
        // alarm sources one by one, then thermal hysteresis
        for (int s = 0; s < 3; s++) begin
            open_loop_det = (s == 0);
            low_headroom_det = (s == 1);
            die_temp_c = (s == 2) ? 8'h8f : 8'h19;
            cyc(6);
            chk(16'(fault_n_oe), 16'h0001);
        end
        die_temp_c = 8'h7c;
        cyc(6);
        chk(16'(fault_n_oe), 16'h0001);
        die_temp_c = 8'h7b;
        cyc(6);
        chk(16'(fault_n_oe), 16'h0000);
        die_temp_c = 8'h8e;
        cyc(6);
        chk(16'(fault_n_oe), 16'h0000);
        // watchdog at each period: serviced, expired, sticky, disabled
        for (int p = 0; p < 4; p++) begin
            t = (p + 1) * T0 * 125 / 8;
            wr(ADDR_CFG, 16'(1 + 2 * p));
            repeat (2) begin
                cyc(t * 6 / 10);
                wr(ADDR_WDOG, 16'h0000);
            end
            chk(16'(fault_n_oe), 16'h0000);
            cyc(t * 13 / 10);
            chk(16'(fault_n_oe), 16'h0001);
            wr(ADDR_WDOG, 16'h0000);
            chk(16'(fault_n_oe), 16'h0001);
            wr(ADDR_CFG, 16'h0000);
            chk(16'(fault_n_oe), 16'h0000);
        end
        // checked frames: good, corrupted, sticky fault, readback
        wr(ADDR_CFG, 16'h0008);
        crc_on = 1'b1;
        u_dfc_host_model.nop();
        c = {$random(seed)} % 65536;
        wr(ADDR_CODE, 16'(c));
        exp_q = cal(c, g, z);
        chk(output_code_q, exp_q);
        u_dfc_host_model.send({ADDR_CODE, 16'(c + 1),
            u_dfc_host_model.crc8({ADDR_CODE, 16'(c + 1)}) ^ 8'h01}, 32);
        cyc(4);
        chk(output_code_q, exp_q);
        chk(16'(fault_n_oe), 16'h0001);
        wr(ADDR_GAIN, CODE_MID);
        wr(ADDR_READ, {8'h00, ADDR_GAIN});
        wr(ADDR_WDOG, 16'h0000);
        chk(u_dfc_host_model.rx_word[31:16], {ADDR_GAIN, 8'h80});
        chk(u_dfc_host_model.rx_word[15:0], {8'h00,
            u_dfc_host_model.crc8({ADDR_GAIN, CODE_MID})});
        chk(16'(fault_n_oe), 16'h0001);
        wr(ADDR_SWRST, 16'h0000);
        crc_on = 1'b0;
        chk(16'(fault_n_oe), 16'h0000);
        chk(output_code_q, CODE_LO);
        finish_test();
    end
endmodule // dfc_top_tb_top
